// [src/hlc_loop_ctrl.sv]
`timescale 1ns/1ps
`include "hlc_params.svh"

// Overview of operation
// - four independent loops, each with start register, counter and active flag
// - start-setup instruction writes the loop start address register
// - count-enable instruction loads the counter and activates the loop
// - start and count registers keep their values until rewritten
// - short loops of one or two sets replay with no further fetches
// - short loops stay interruptible and resume after service
// - loop targets are absolute start addresses, never pc-relative
// - no endless loop form; every loop ends when its count runs out
// - bypass instruction jumps to label when count is zero or negative
// - early restart with count above 1 returns to loop start
// - early restart with count at most 1 leaves to the label
// - delayed restart acts after its delay-slot set executes
// - predicated exit leaves the loop only when the condition holds
// - aligned loop starts need one fetch fewer than unaligned ones at a loop-end wrap
module hlc_loop_ctrl (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic                          op_valid,
  input  wire hlc_pkg::hlc_op_t              op_kind,
  input  wire logic [1:0]                    op_loop,
  input  wire logic [`HLC_ADDR_W-1:0]        op_addr,
  input  wire logic signed [`HLC_CNT_W-1:0]  op_count,
  input  wire logic                          op_pred,
  input  wire logic                          op_cond,
  input  wire logic                          ex_valid,
  input  wire logic [`HLC_ADDR_W-1:0]        ex_pc,
  input  wire logic [`HLC_SET_W-1:0]         ex_set,
  input  wire logic                          irq_take,
  input  wire logic                          irq_return,
  output logic                               redirect_q,
  output logic [`HLC_ADDR_W-1:0]             redirect_addr_q,
  output logic                               redirect_extra_fetch_q,
  output logic                               fetch_hold_q,
  output logic                               replay_valid_q,
  output logic [`HLC_SET_W-1:0]              replay_set_q,
  output logic [`HLC_NUM_LOOPS-1:0]          loop_flags_q
);

  localparam int NL = `HLC_NUM_LOOPS;

  logic [`HLC_ADDR_W-1:0]       loop_begin_pointer_q     [NL];
  logic [`HLC_ADDR_W-1:0]       loop_final_address_q     [NL];
  logic signed [`HLC_CNT_W-1:0] loop_iteration_counter_q [NL];
  logic [NL-1:0]                short_q;
  logic                         short_run_q;
  logic                         two_sets_q;
  logic                         isr_q;
  logic                         pend_q;
  logic [`HLC_ADDR_W-1:0]       pend_lbl_q;

  logic [1:0]                   in_idx;
  logic                         any_act;
  logic                         at_end;
  logic signed [`HLC_CNT_W-1:0] cnt_in;
  hlc_pkg::hlc_op_t             act_op;
  logic                         restart_now;
  logic [`HLC_ADDR_W-1:0]       restart_lbl;
  logic                         exit_now;
  logic                         bypass_now;
  logic                         op_flow;
  logic                         end_wrap;
  logic                         end_done;
  logic                         short_run_d;
  logic                         isr_d;

  hlc_slb_if slb ();

  hlc_short_buf u_buf (
    .clock (clock),
    .slb   (slb.buf_side)
  );

  // innermost active loop: higher numbers always nest inside lower ones
  function automatic logic [1:0] inner_loop(input logic [NL-1:0] f);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < NL; i++) begin
      if (f[i]) r = 2'(i);
    end
    return r;
  endfunction

  // decisions of this cycle; bypass, restart and exit win over the loop-end wrap
  always_comb begin
    in_idx      = inner_loop(loop_flags_q);
    any_act     = |loop_flags_q;
    cnt_in      = loop_iteration_counter_q[in_idx];
    at_end      = ex_valid && !isr_q && any_act && (ex_pc == loop_final_address_q[in_idx]);
    act_op      = op_valid ? op_kind : hlc_pkg::OP_NONE;
    restart_now = any_act && ((act_op == hlc_pkg::OP_RESTART) || (pend_q && ex_valid));
    restart_lbl = (act_op == hlc_pkg::OP_RESTART) ? op_addr : pend_lbl_q;
    exit_now    = any_act && (act_op == hlc_pkg::OP_EXIT) && (!op_pred || op_cond);
    bypass_now  = (act_op == hlc_pkg::OP_BYPASS)
                  && (loop_iteration_counter_q[op_loop] <= `HLC_CNT_ZERO);
    op_flow     = restart_now || exit_now || bypass_now;
    end_wrap    = at_end && !op_flow && (cnt_in > `HLC_CNT_ONE);
    end_done    = at_end && !op_flow && !(cnt_in > `HLC_CNT_ONE);
    isr_d       = irq_take ? 1'b1 : (irq_return ? 1'b0 : isr_q);
    short_run_d = short_run_q;
    if (end_wrap && short_q[in_idx]) short_run_d = 1'b1;
    if (end_done || op_flow) short_run_d = 1'b0;
  end

  // per-loop registers hold until an instruction or a loop end rewrites them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NL; i++) begin
        loop_begin_pointer_q[i]     <= `HLC_ADDR_RST;
        loop_final_address_q[i]     <= `HLC_ADDR_RST;
        loop_iteration_counter_q[i] <= `HLC_CNT_RST;
      end
      loop_flags_q <= '0;
      short_q      <= '0;
    end else begin
      if (act_op == hlc_pkg::OP_SETUP) begin
        loop_begin_pointer_q[op_loop] <= op_addr;
      end
      if (bypass_now) begin
        loop_flags_q[op_loop] <= 1'b0;
      end
      if (restart_now) begin
        if (cnt_in > `HLC_CNT_ONE) begin
          loop_iteration_counter_q[in_idx] <= cnt_in - `HLC_CNT_ONE;
        end else begin
          loop_flags_q[in_idx] <= 1'b0;
        end
      end
      if (exit_now) begin
        loop_flags_q[in_idx] <= 1'b0;
      end
      if (end_wrap) begin
        loop_iteration_counter_q[in_idx] <= cnt_in - `HLC_CNT_ONE;
      end
      if (end_done) begin
        loop_flags_q[in_idx] <= 1'b0;
      end
      // count-enable comes last: a new loop beats a same-cycle end or restart
      if (act_op == hlc_pkg::OP_ENABLE || act_op == hlc_pkg::OP_ENABLE_SHORT) begin
        loop_iteration_counter_q[op_loop] <= op_count;
        loop_final_address_q[op_loop]     <= op_addr;
        loop_flags_q[op_loop]             <= 1'b1;
        short_q[op_loop]                  <= (act_op == hlc_pkg::OP_ENABLE_SHORT);
      end
    end
  end

  // delayed restart waits for its delay-slot set to complete
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_q     <= 1'b0;
      pend_lbl_q <= `HLC_ADDR_RST;
    end else if (act_op == hlc_pkg::OP_RESTART_DLY && any_act) begin
      pend_q     <= 1'b1;
      pend_lbl_q <= op_addr;
    end else if (ex_valid) begin
      pend_q <= 1'b0;
    end
  end

  // interrupt service suspends wrap and replay but keeps all loop state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      isr_q <= 1'b0;
    end else begin
      isr_q <= isr_d;
    end
  end

  // redirects go to the stored absolute start or the instruction's label; nothing is added to the pc
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      redirect_q             <= 1'b0;
      redirect_addr_q        <= `HLC_ADDR_RST;
      redirect_extra_fetch_q <= 1'b0;
    end else begin
      redirect_q <= 1'b0;
      if (bypass_now || exit_now) begin
        redirect_q      <= 1'b1;
        redirect_addr_q <= op_addr;
      end else if (restart_now) begin
        redirect_q      <= 1'b1;
        redirect_addr_q <= (cnt_in > `HLC_CNT_ONE) ? loop_begin_pointer_q[in_idx]
                                                    : restart_lbl;
      end else if (end_wrap && !short_q[in_idx]) begin
        redirect_q      <= 1'b1;
        redirect_addr_q <= loop_begin_pointer_q[in_idx];
        // an unaligned start straddles fetch sets and costs one more fetch
        redirect_extra_fetch_q <=
          |loop_begin_pointer_q[in_idx][`HLC_ALIGN_BITS-1:0];
      end
    end
  end

  // first pass fills the buffer; later passes are served from it
  assign slb.wr_en   = ex_valid && !isr_q && any_act && short_q[in_idx] && !short_run_q;
  assign slb.wr_idx  = (ex_pc != loop_begin_pointer_q[in_idx]);
  assign slb.wr_data = ex_set;
  assign slb.rd_idx  = two_sets_q && (ex_pc != loop_final_address_q[in_idx]);

  // replay state; fetch hold drops during service so the handler can fetch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      short_run_q    <= 1'b0;
      two_sets_q     <= 1'b0;
      fetch_hold_q   <= 1'b0;
      replay_valid_q <= 1'b0;
      replay_set_q   <= `HLC_SET_RST;
    end else begin
      short_run_q    <= short_run_d;
      fetch_hold_q   <= short_run_d && !isr_d;
      replay_valid_q <= short_run_d && !isr_d && ex_valid && !isr_q;
      if (short_run_d && !isr_d && ex_valid && !isr_q) begin
        replay_set_q <= slb.rd_data;
      end
      if (act_op == hlc_pkg::OP_ENABLE_SHORT) begin
        two_sets_q <= 1'b0;
      end else if (slb.wr_en && slb.wr_idx) begin
        two_sets_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_setup_store: assert property (op_valid && op_kind == hlc_pkg::OP_SETUP
    |=> loop_begin_pointer_q[$past(op_loop)] == $past(op_addr))
    else $error("start register not written by setup");
  a_enable_load: assert property (op_valid && op_kind == hlc_pkg::OP_ENABLE
    |=> loop_flags_q[$past(op_loop)]
    && loop_iteration_counter_q[$past(op_loop)] == $past(op_count))
    else $error("count-enable did not load and activate");
  a_wrap_target: assert property (end_wrap && !short_q[in_idx]
    |=> redirect_q && redirect_addr_q == $past(loop_begin_pointer_q[in_idx]))
    else $error("loop wrap not to stored start");
  a_end_clear: assert property (end_done && !(op_loop == in_idx
    && act_op inside {hlc_pkg::OP_ENABLE, hlc_pkg::OP_ENABLE_SHORT})
    |=> !loop_flags_q[$past(in_idx)] && !redirect_q)
    else $error("finished loop still active");
  a_bypass_jump: assert property (bypass_now
    |=> redirect_q && redirect_addr_q == $past(op_addr) && !loop_flags_q[$past(op_loop)])
    else $error("bypass did not jump");
  a_restart_exit: assert property (restart_now && !(cnt_in > `HLC_CNT_ONE)
    && !exit_now && !bypass_now |=> redirect_q && redirect_addr_q == $past(restart_lbl))
    else $error("final-pass restart did not leave");
  a_exit_false: assert property (op_valid && op_kind == hlc_pkg::OP_EXIT
    && op_pred && !op_cond && !at_end && !restart_now |=> !redirect_q)
    else $error("exit taken with false condition");
  a_irq_release: assert property (irq_take |=> !fetch_hold_q && !replay_valid_q)
    else $error("fetch held during interrupt");
  a_replay_hold: assert property (replay_valid_q |-> fetch_hold_q && $past(short_run_d))
    else $error("replay without fetch hold");
  a_delay_slot: assert property (op_valid && op_kind == hlc_pkg::OP_RESTART_DLY
    && any_act ##1 (!ex_valid && !op_valid) |=> !redirect_q)
    else $error("delayed restart acted before its slot");

endmodule

// [src/hlc_params.svh]
`ifndef HLC_PARAMS_SVH
`define HLC_PARAMS_SVH

// loop resources and datapath widths
`define HLC_NUM_LOOPS   4
`define HLC_ADDR_W      32
`define HLC_CNT_W       16
`define HLC_SET_W       64
// a fetch set spans 8 bytes; a loop start on this boundary saves one fetch
`define HLC_ALIGN_BITS  3

// reset values and count thresholds
`define HLC_ADDR_RST    32'h0000_0000
`define HLC_CNT_RST     16'sh0000
`define HLC_CNT_ZERO    16'sh0000
`define HLC_CNT_ONE     16'sh0001
`define HLC_SET_RST     64'h0000_0000_0000_0000

`endif

// [src/hlc_pkg.sv]
package hlc_pkg;

  // loop instruction classes as seen by the sequencer
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SETUP,
    OP_ENABLE,
    OP_ENABLE_SHORT,
    OP_BYPASS,
    OP_RESTART,
    OP_RESTART_DLY,
    OP_EXIT
  } hlc_op_t;

endpackage

// [src/hlc_slb_if.sv]
`timescale 1ns/1ps
`include "hlc_params.svh"

// short-loop buffer port: capture on the first pass, read on replay
interface hlc_slb_if;
  logic                  wr_en;
  logic                  wr_idx;
  logic [`HLC_SET_W-1:0] wr_data;
  logic                  rd_idx;
  logic [`HLC_SET_W-1:0] rd_data;

  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport buf_side (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// [src/hlc_short_buf.sv]
`timescale 1ns/1ps
`include "hlc_params.svh"

module hlc_short_buf (
  input wire logic    clock,
  hlc_slb_if.buf_side slb
);

  // two execution sets are the most a short loop may hold
  logic [`HLC_SET_W-1:0] mem [2];

  // capture during the first pass only; no reset needed, replay reads after capture
  always_ff @(posedge clock) begin
    if (slb.wr_en) begin
      mem[slb.wr_idx] <= slb.wr_data;
    end
  end

  assign slb.rd_data = mem[slb.rd_idx];

endmodule

// [bench/hlc_prog_model.sv]
`timescale 1ns/1ps
`include "hlc_params.svh"

// straight-line program stream: one set every other cycle, so a redirect lands first
// nests loops by rising number only, one enable per loop start
module hlc_prog_model (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   run,
  input  wire logic                   load,
  input  wire logic [`HLC_ADDR_W-1:0] beg,
  input  wire logic [`HLC_ADDR_W-1:0] fin,
  input  wire logic                   redirect_q,
  input  wire logic [`HLC_ADDR_W-1:0] redirect_addr_q,
  input  wire logic [3:0]             loop_flags_q,
  output logic                        ex_valid,
  output logic [`HLC_ADDR_W-1:0]      ex_pc,
  output logic [`HLC_SET_W-1:0]       ex_set
);
  logic [`HLC_ADDR_W-1:0] last_q;
  logic [`HLC_ADDR_W-1:0] nxt;

  // no branches near loop ends, no flag moves: redirects steer, and fin wraps to beg while any loop flag is set
  assign nxt = redirect_q ? redirect_addr_q :
               (last_q == fin && |loop_flags_q) ? beg : last_q + 32'h8;

  // idle cycles show inverted lines, except a load cycle, which keeps the last set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_q   <= 32'h0;
      ex_valid <= 1'b0;
      ex_pc    <= 32'h0;
      ex_set   <= 64'h0;
    end else if (load) begin
      last_q   <= beg - 32'h8;
      ex_valid <= 1'b0;
    end else if (run && !ex_valid) begin
      last_q   <= nxt;
      ex_valid <= 1'b1;
      ex_pc    <= nxt;
      ex_set   <= {nxt, ~nxt};
    end else begin
      ex_valid <= 1'b0;
      ex_pc    <= ~ex_pc;
      ex_set   <= ~ex_set;
    end
  end
endmodule

// [bench/tb_hardware_loop_control.sv]
`timescale 1ns/1ps
`include "hlc_params.svh"
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end

module tb_hardware_loop_control;
  logic               clock = 1'b0;
  logic               rst_n = 1'b0;
  logic               op_valid = 1'b0;
  hlc_pkg::hlc_op_t   op_kind = hlc_pkg::OP_NONE;
  logic [1:0]         op_loop = 2'h0;
  logic [31:0]        op_addr = 32'h0;
  logic signed [15:0] op_count = 16'sh0;
  logic               op_pred = 1'b0;
  logic               op_cond = 1'b0;
  logic               irq_take = 1'b0;
  logic               irq_return = 1'b0;
  logic               run = 1'b0;
  logic               load = 1'b0;
  logic [31:0]        beg = 32'h0;
  logic [31:0]        fin = 32'h0;
  logic               ex_valid;
  logic [31:0]        ex_pc;
  logic [63:0]        ex_set;
  logic               redirect_q;
  logic [31:0]        redirect_addr_q;
  logic               redirect_extra_fetch_q;
  logic               fetch_hold_q;
  logic               replay_valid_q;
  logic [63:0]        replay_set_q;
  logic [3:0]         loop_flags_q;
  logic [31:0]        nx;
  logic               seen;
  int                 k;
  int                 failures = 0;
  int                 tests_run = 0;

  hlc_loop_ctrl i_dut (.clock(clock), .rst_n(rst_n), .op_valid(op_valid), .op_kind(op_kind),
    .op_loop(op_loop), .op_addr(op_addr), .op_count(op_count), .op_pred(op_pred),
    .op_cond(op_cond), .ex_valid(ex_valid), .ex_pc(ex_pc), .ex_set(ex_set),
    .irq_take(irq_take), .irq_return(irq_return), .redirect_q(redirect_q),
    .redirect_addr_q(redirect_addr_q), .redirect_extra_fetch_q(redirect_extra_fetch_q),
    .fetch_hold_q(fetch_hold_q), .replay_valid_q(replay_valid_q),
    .replay_set_q(replay_set_q), .loop_flags_q(loop_flags_q));

  hlc_prog_model i_model (.clock(clock), .rst_n(rst_n), .run(run), .load(load), .beg(beg),
    .fin(fin), .redirect_q(redirect_q), .redirect_addr_q(redirect_addr_q),
    .loop_flags_q(loop_flags_q), .ex_valid(ex_valid), .ex_pc(ex_pc), .ex_set(ex_set));

  // 20 MHz core clock
  always #25 clock = ~clock;

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // one loop instruction, held through the edge that takes it
  task automatic op(input hlc_pkg::hlc_op_t o, input logic [1:0] n, input logic [31:0] a,
                    input logic signed [15:0] c, input logic [1:0] pc);
    @(posedge clock);
    op_valid <= 1'b1;
    op_kind  <= o;
    op_loop  <= n;
    op_addr  <= a;
    op_count <= c;
    op_pred  <= pc[1];
    op_cond  <= pc[0];
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic start(input logic [31:0] b, input logic [31:0] f);
    @(posedge clock);
    beg  <= b;
    fin  <= f;
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    run  <= 1'b1;
    #1;
  endtask

  // long loop, count 2: one wrap, then fall through
  task automatic t_long(input logic [31:0] b, input logic [31:0] f, input logic x);
    op(hlc_pkg::OP_SETUP, 2'h2, b, 16'sh0, 2'h0);
    repeat (3) @(posedge clock);
    op(hlc_pkg::OP_ENABLE, 2'h2, f, 16'sh2, 2'h0);
    `CHK("flags", 4'h4, loop_flags_q)
    start(b, f);
    for (k = 0; k < 20 && redirect_q !== 1'b1; k++) step();
    `CHK("wrap", b, redirect_addr_q)
    `CHK("align", x, redirect_extra_fetch_q)
    seen = 1'b0;
    for (k = 0; k < 20 && loop_flags_q !== 4'h0; k++) begin
      step();
      seen = seen | redirect_q;
    end
    `CHK("flags", 4'h0, loop_flags_q)
    `CHK("rewrap", 1'b0, seen)
    @(posedge clock);
    run <= 1'b0;
  endtask

  // bypass on zero and negative counts, not on positive; predicated exit
  task automatic t_bypass();
    for (k = 0; k < 2; k++) begin
      op(hlc_pkg::OP_ENABLE, 2'h1, 32'h300, 16'(-k), 2'h0);
      op(hlc_pkg::OP_BYPASS, 2'h1, 32'h400, 16'sh0, 2'h0);
      `CHK("skip", 1'b1, redirect_q)
      `CHK("label", 32'h400, redirect_addr_q)
      `CHK("flags", 4'h0, loop_flags_q)
    end
    op(hlc_pkg::OP_ENABLE, 2'h1, 32'h300, 16'sh5, 2'h0);
    op(hlc_pkg::OP_BYPASS, 2'h1, 32'h400, 16'sh0, 2'h0);
    `CHK("noskip", 1'b0, redirect_q)
    `CHK("flags", 4'h2, loop_flags_q)
    op(hlc_pkg::OP_EXIT, 2'h0, 32'h410, 16'sh0, 2'h2);
    `CHK("flags", 4'h2, loop_flags_q)
    op(hlc_pkg::OP_EXIT, 2'h0, 32'h410, 16'sh0, 2'h3);
    `CHK("flags", 4'h0, loop_flags_q)
    `CHK("exit", 32'h410, redirect_addr_q)
  endtask

  // restart count 3: twice to start, then out to the label; delayed form waits a set
  task automatic t_restart();
    op(hlc_pkg::OP_SETUP, 2'h0, 32'h500, 16'sh0, 2'h0);
    op(hlc_pkg::OP_ENABLE, 2'h0, 32'h540, 16'sh3, 2'h0);
    for (k = 0; k < 3; k++) begin
      op(hlc_pkg::OP_RESTART, 2'h0, 32'h600, 16'sh0, 2'h0);
      `CHK("redir", 1'b1, redirect_q)
      `CHK("loop_restart_early_op", (k < 2) ? 32'h500 : 32'h600, redirect_addr_q)
    end
    `CHK("flags", 4'h0, loop_flags_q)
    op(hlc_pkg::OP_ENABLE, 2'h0, 32'h540, 16'sh3, 2'h0);
    op(hlc_pkg::OP_RESTART_DLY, 2'h0, 32'h600, 16'sh0, 2'h0);
    `CHK("slot", 1'b0, redirect_q)
    start(32'h510, 32'h540);
    for (k = 0; k < 8 && ex_valid !== 1'b1; k++) step();
    @(posedge clock);
    run <= 1'b0;
    #1;
    `CHK("dly", 1'b1, redirect_q)
    `CHK("dlyad", 32'h500, redirect_addr_q)
    op(hlc_pkg::OP_EXIT, 2'h0, 32'h700, 16'sh0, 2'h0);
  endtask

  // two-set short loop, interrupted while replaying
  task automatic t_short();
    op(hlc_pkg::OP_SETUP, 2'h0, 32'h200, 16'sh0, 2'h0);
    op(hlc_pkg::OP_ENABLE_SHORT, 2'h0, 32'h208, 16'sh4, 2'h0);
    start(32'h200, 32'h208);
    for (k = 0; k < 20 && fetch_hold_q !== 1'b1; k++) step();
    for (k = 0; k < 8 && replay_valid_q !== 1'b1; k++) step();
    `CHK("repv", 1'b1, replay_valid_q)
    nx = (i_model.last_q == 32'h200) ? 32'h208 : 32'h200;
    `CHK("replay", {nx, ~nx}, replay_set_q)
    @(posedge clock);
    irq_take <= 1'b1;
    run      <= 1'b0;
    @(posedge clock);
    irq_take <= 1'b0;
    #1;
    `CHK("irqhold", 1'b0, fetch_hold_q)
    `CHK("irqrep", 1'b0, replay_valid_q)
    repeat (3) @(posedge clock);
    irq_return <= 1'b1;
    run        <= 1'b1;
    @(posedge clock);
    irq_return <= 1'b0;
    for (k = 0; k < 8 && fetch_hold_q !== 1'b1; k++) step();
    `CHK("resume", 1'b1, fetch_hold_q)
    for (k = 0; k < 40 && loop_flags_q !== 4'h0; k++) step();
    `CHK("flags", 4'h0, loop_flags_q)
    step();
    `CHK("release", 1'b0, fetch_hold_q)
    @(posedge clock);
    run <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_long(32'h104, 32'h114, 1'b1);
    t_long(32'h100, 32'h108, 1'b0);
    t_bypass();
    t_restart();
    t_short();
    conclude();
  end

  // the tests need well under a thousand cycles
  initial begin
    #(50 * 3000);
    failures++;
    conclude();
  end
endmodule
